// file: src/fslc_top.v
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "fslc_defines.vh"

// Overview of operation
// RL1 - suspend command during a write stops it at a fixed point; reads keep returning status
// RL2 - once suspended, ready and write-suspended flags read one; status pin floats
// RL3 - while suspended only read array, read status and resume are accepted
// RL4 - resume continues the write, clears suspend and ready flags, pin driven low
// RL5 - host holds write-protect at a valid level while a write is suspended
// RL6 - lock set is setup then confirm with block address; then machine runs
// RL7 - host checks program error after lock set; interface stays in status mode
// RL8 - bad lock-set sequence sets program and erase errors, lock bits unchanged
// RL9 - lock set with write-protect low fails, sets lock violation and program error
// RL10 - lock clear is two writes, clears all lock bits together, then status
// RL11 - bad lock-clear sequence sets program and erase errors
// RL12 - lock clear at low supply sets supply-low and erase error, no change
// RL13 - lock clear with write-protect low fails, sets lock violation and erase error
// RL14 - lock clear aborted by reset leaves lock bits undetermined until repeated
// RL15 - pin configuration persists until reconfigured, power loss or reset pin low
// RL16 - after reset pin is in level mode: low when busy, floating when ready
// RL17 - pin configuration is command plus code; ignores supply, needs reset pin high
// RL18 - code 00 selects level ready/busy mode
// RL19 - code 01 pulses pin low when block erase, chip erase or lock clear ends
// RL20 - code 02 pulses on write or lock set end; code 03 on any of them
// RL21 - write or erase on locked block refused with write-protect low, else allowed
// RL22 - chip erase skips locked blocks with write-protect low, erases all if high
// RL23 - in pulse modes pin floats except for a fixed-length low completion pulse
module fslc_top #(
  parameter BLK_W = 6,
  parameter NBLK = 64,
  parameter CNT_W = 16,
  parameter [15:0] OP_CYCLES = `FSLC_OP_CYCLES,
  parameter [15:0] SUSPEND_CYCLES = `FSLC_SUSPEND_CYCLES,
  parameter [15:0] PULSE_CYCLES = `FSLC_PULSE_CYCLES
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [7:0] awaddr,
  input wire [2:0] awprot,
  input wire awvalid,
  output reg awready,
  // axi4-lite write data
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // axi4-lite write response
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // axi4-lite read address
  input wire [7:0] araddr,
  input wire [2:0] arprot,
  input wire arvalid,
  output reg arready,
  // axi4-lite read data
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // device pins
  input wire write_protect_n,
  input wire reset_powerdown_n,
  input wire program_supply_lockout_level,
  output reg status_pin_out,
  output reg status_pin_oe
);

  // ****************************************
  // state codes
  // ****************************************
  localparam [2:0] W_IDLE = 3'h0;
  localparam [2:0] W_RUN = 3'h1;
  localparam [2:0] W_SPEND = 3'h2;
  localparam [2:0] W_SUSP = 3'h3;
  localparam [2:0] W_DONE = 3'h4;

  localparam [2:0] C_READY = 3'h0;
  localparam [2:0] C_WR = 3'h1;
  localparam [2:0] C_ERA = 3'h2;
  localparam [2:0] C_CHIP = 3'h3;
  localparam [2:0] C_LOCK = 3'h4;
  localparam [2:0] C_CFG = 3'h5;

  localparam [2:0] OP_WRITE = 3'h0;
  localparam [2:0] OP_ERASE = 3'h1;
  localparam [2:0] OP_CHIP = 3'h2;
  localparam [2:0] OP_SETLK = 3'h3;
  localparam [2:0] OP_CLRLK = 3'h4;

  // ****************************************
  // functions
  // ****************************************
  // program-type operations report on the program error flag
  function is_prog_op;
    input [2:0] op;
    begin
      is_prog_op = (op == OP_WRITE) || (op == OP_SETLK);
    end
  endfunction

  // completion class: bit0 erase kind, bit1 write kind
  function [1:0] op_class;
    input [2:0] op;
    begin
      op_class = is_prog_op(op) ? 2'h2 : 2'h1;
    end
  endfunction

  // fault at launch: {supply low, lock violation}
  function [1:0] launch_fault;
    input [2:0] op;
    input locked;
    input wp_low;
    input sup_low;
    begin
      launch_fault[1] = sup_low;
      case (op)
        OP_SETLK, OP_CLRLK: launch_fault[0] = wp_low;
        OP_WRITE, OP_ERASE: launch_fault[0] = wp_low & locked;
        default: launch_fault[0] = 1'b0;
      endcase
    end
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  wire [2:0] pins_sync;
  wire wp_low;
  wire rp_high;
  wire sup_low;

  fslc_sync #(
    .WIDTH(3)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({write_protect_n, reset_powerdown_n, program_supply_lockout_level}),
    .sync_out(pins_sync)
  );

  assign wp_low = ~pins_sync[2];
  assign rp_high = pins_sync[1];
  assign sup_low = pins_sync[0];

  // ****************************************
  // state
  // ****************************************
  reg aw_got;
  reg w_got;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg w_lane0;
  reg [2:0] write_state_machine;
  reg [2:0] command_user_interface;
  reg [2:0] op;
  reg [BLK_W-1:0] op_blk;
  reg op_fail;
  reg [CNT_W-1:0] op_cnt;
  reg [CNT_W-1:0] susp_cnt;
  reg [CNT_W-1:0] pulse_cnt;
  reg [NBLK-1:0] lock_bits;
  reg lock_unknown;
  reg chip_skipped;
  reg read_array;
  reg [1:0] pin_mode;
  reg erase_err;
  reg prog_err;
  reg supply_low;
  reg lock_viol;

  wire wr_fire;
  wire cmd_wr;
  wire [7:0] code;
  wire [BLK_W-1:0] blk;
  wire busy;
  wire ready;
  wire write_susp;
  wire [31:0] status_word;
  wire [31:0] info_word;

  assign wr_fire = aw_got & w_got & ~bvalid;
  assign cmd_wr = wr_fire & (aw_addr == `FSLC_REG_CMD) & w_lane0;
  assign code = w_data[`FSLC_CMD_CODE_LSB +: 8];
  assign blk = w_data[`FSLC_CMD_BLK_LSB +: BLK_W];
  assign busy = (write_state_machine == W_RUN) || (write_state_machine == W_SPEND) || (write_state_machine == W_DONE);
  assign ready = ~busy; // RL2
  assign write_susp = (write_state_machine == W_SUSP); // RL2

  assign status_word = {24'h000000, ready, 1'b0, erase_err, prog_err, supply_low, write_susp, lock_viol, 1'b0};
  assign info_word = {27'h0000000, read_array, pin_mode, chip_skipped, lock_unknown};

  // ****************************************
  // axi4-lite write channels
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `FSLC_RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_lane0 <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_got <= 1'b1;
        aw_addr <= awaddr;
      end else if (!aw_got && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_got <= 1'b1;
        w_data <= wdata;
        w_lane0 <= wstrb[0];
      end else if (!w_got && !bvalid) begin
        wready <= 1'b1;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        case (aw_addr)
          `FSLC_REG_CMD, `FSLC_REG_STATUS, `FSLC_REG_LOCK_LO, `FSLC_REG_LOCK_HI, `FSLC_REG_INFO: begin
            bresp <= `FSLC_RESP_OKAY;
          end
          default: begin
            bresp <= `FSLC_RESP_SLVERR;
          end
        endcase
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // axi4-lite read channels
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `FSLC_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= `FSLC_RESP_OKAY;
        case (araddr)
          `FSLC_REG_CMD: rdata <= 32'h00000000;
          `FSLC_REG_STATUS: rdata <= status_word;
          `FSLC_REG_LOCK_LO: rdata <= lock_bits[31:0];
          `FSLC_REG_LOCK_HI: rdata <= lock_bits[63:32];
          `FSLC_REG_INFO: rdata <= info_word;
          default: begin
            rdata <= 32'h00000000;
            rresp <= `FSLC_RESP_SLVERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end else if (!rvalid && !arready) begin
        arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // command interface and write state machine
  // ****************************************
  reg [2:0] l_op;
  reg l_go;
  reg [1:0] fault;

  always @* begin
    l_go = 1'b0;
    l_op = OP_WRITE;
    case (command_user_interface)
      C_WR: begin
        l_go = 1'b1;
        l_op = OP_WRITE;
      end
      C_ERA: begin
        l_go = (code == `FSLC_CMD_CONFIRM);
        l_op = OP_ERASE;
      end
      C_CHIP: begin
        l_go = (code == `FSLC_CMD_CONFIRM);
        l_op = OP_CHIP;
      end
      C_LOCK: begin
        l_go = (code == `FSLC_CMD_LOCK_SET) || (code == `FSLC_CMD_CONFIRM);
        l_op = (code == `FSLC_CMD_LOCK_SET) ? OP_SETLK : OP_CLRLK; // RL6 RL10
      end
      default: begin
        l_go = 1'b0;
      end
    endcase
    fault = launch_fault(l_op, lock_bits[blk], wp_low, sup_low); // RL9 RL12 RL13 RL21
  end

  always @(posedge aclk) begin
    if (!aresetn || !rp_high) begin
      if (aresetn && write_state_machine != W_IDLE && op == OP_CLRLK) begin
        lock_unknown <= 1'b1; // RL14
      end else if (!aresetn) begin
        lock_unknown <= 1'b0;
      end
      if (!aresetn) begin
        lock_bits <= {NBLK{1'b0}};
        chip_skipped <= 1'b0;
      end
      write_state_machine <= W_IDLE;
      command_user_interface <= C_READY;
      op <= OP_WRITE;
      op_blk <= {BLK_W{1'b0}};
      op_fail <= 1'b0;
      op_cnt <= {CNT_W{1'b0}};
      susp_cnt <= {CNT_W{1'b0}};
      read_array <= 1'b1;
      pin_mode <= `FSLC_PIN_LEVEL; // RL15 RL16
      erase_err <= 1'b0;
      prog_err <= 1'b0;
      supply_low <= 1'b0;
      lock_viol <= 1'b0;
    end else begin
      case (write_state_machine)
        W_RUN: begin
          if (cmd_wr && code == `FSLC_CMD_SUSPEND && op == OP_WRITE) begin
            write_state_machine <= W_SPEND; // RL1
            susp_cnt <= SUSPEND_CYCLES;
          end else if (op_cnt <= 16'h0001) begin
            write_state_machine <= W_DONE;
          end else begin
            op_cnt <= op_cnt - 16'h0001;
          end
        end
        W_SPEND: begin
          if (susp_cnt <= 16'h0001) begin
            write_state_machine <= W_SUSP; // RL2
          end else begin
            susp_cnt <= susp_cnt - 16'h0001;
          end
        end
        W_SUSP: begin
          if (cmd_wr) begin
            case (code)
              `FSLC_CMD_READ_ARRAY: read_array <= 1'b1; // RL3
              `FSLC_CMD_READ_STATUS: read_array <= 1'b0; // RL3
              `FSLC_CMD_CONFIRM: begin
                write_state_machine <= W_RUN; // RL4
                read_array <= 1'b0;
              end
              default: begin
                write_state_machine <= W_SUSP; // RL3
              end
            endcase
          end
        end
        W_DONE: begin
          write_state_machine <= W_IDLE;
          if (!op_fail) begin
            case (op)
              OP_SETLK: lock_bits[op_blk] <= 1'b1;
              OP_CLRLK: begin
                lock_bits <= {NBLK{1'b0}}; // RL10
                lock_unknown <= 1'b0;
              end
              OP_CHIP: chip_skipped <= wp_low & (|lock_bits); // RL22
              default: chip_skipped <= chip_skipped;
            endcase
          end
        end
        default: begin
          if (cmd_wr) begin
            read_array <= 1'b0;
            if (command_user_interface == C_READY) begin
              case (code)
                `FSLC_CMD_READ_ARRAY: read_array <= 1'b1;
                `FSLC_CMD_CLEAR_STATUS: begin
                  erase_err <= 1'b0;
                  prog_err <= 1'b0;
                  supply_low <= 1'b0;
                  lock_viol <= 1'b0;
                end
                `FSLC_CMD_WRITE_SETUP, `FSLC_CMD_WRITE_SETUP_ALT: command_user_interface <= C_WR;
                `FSLC_CMD_ERASE_SETUP: command_user_interface <= C_ERA;
                `FSLC_CMD_CHIP_SETUP: command_user_interface <= C_CHIP;
                `FSLC_CMD_LOCK_SETUP: command_user_interface <= C_LOCK;
                `FSLC_CMD_PIN_CONFIG: command_user_interface <= C_CFG; // RL17
                default: command_user_interface <= C_READY;
              endcase
            end else if (command_user_interface == C_CFG) begin
              command_user_interface <= C_READY;
              if (code <= `FSLC_PIN_MAX_CODE) begin
                pin_mode <= code[1:0]; // RL15 RL18 RL19 RL20
              end else begin
                prog_err <= 1'b1;
                erase_err <= 1'b1;
              end
            end else if (l_go) begin
              command_user_interface <= C_READY;
              write_state_machine <= W_RUN; // RL6
              op <= l_op;
              op_blk <= blk;
              op_fail <= |fault;
              op_cnt <= (|fault) ? 16'h0001 : OP_CYCLES;
              if (fault[1]) begin
                supply_low <= 1'b1; // RL12
              end
              if (fault[0]) begin
                lock_viol <= 1'b1; // RL9 RL13 RL21
              end
              if ((|fault) && is_prog_op(l_op)) begin
                prog_err <= 1'b1; // RL9
              end
              if ((|fault) && !is_prog_op(l_op)) begin
                erase_err <= 1'b1; // RL12 RL13
              end
            end else begin
              command_user_interface <= C_READY;
              prog_err <= 1'b1; // RL8 RL11
              erase_err <= 1'b1; // RL8 RL11
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // status pin
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn || !rp_high) begin
      pulse_cnt <= {CNT_W{1'b0}};
      status_pin_oe <= 1'b0;
      status_pin_out <= 1'b0;
    end else begin
      status_pin_out <= 1'b0;
      if (write_state_machine == W_DONE && (pin_mode & op_class(op)) != 2'h0) begin
        pulse_cnt <= PULSE_CYCLES; // RL19 RL20
      end else if (pulse_cnt != {CNT_W{1'b0}}) begin
        pulse_cnt <= pulse_cnt - 16'h0001;
      end
      if (pin_mode == `FSLC_PIN_LEVEL) begin
        status_pin_oe <= (write_state_machine == W_RUN) || (write_state_machine == W_SPEND); // RL2 RL4 RL16 RL18
      end else begin
        status_pin_oe <= (pulse_cnt != {CNT_W{1'b0}}); // RL23
      end
    end
  end

endmodule // fslc_top

// file: src/fslc_defines.vh
`ifndef FSLC_DEFINES_VH
`define FSLC_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define FSLC_REG_CMD 8'h00
`define FSLC_REG_STATUS 8'h04
`define FSLC_REG_LOCK_LO 8'h08
`define FSLC_REG_LOCK_HI 8'h0c
`define FSLC_REG_INFO 8'h10

// ****************************************
// command codes
// ****************************************
`define FSLC_CMD_READ_ARRAY 8'hff
`define FSLC_CMD_READ_STATUS 8'h70
`define FSLC_CMD_CLEAR_STATUS 8'h50
`define FSLC_CMD_WRITE_SETUP 8'h40
`define FSLC_CMD_WRITE_SETUP_ALT 8'h10
`define FSLC_CMD_ERASE_SETUP 8'h20
`define FSLC_CMD_CHIP_SETUP 8'h30
`define FSLC_CMD_CONFIRM 8'hd0
`define FSLC_CMD_SUSPEND 8'hb0
`define FSLC_CMD_LOCK_SETUP 8'h60
`define FSLC_CMD_LOCK_SET 8'h01
`define FSLC_CMD_PIN_CONFIG 8'hb8

// ****************************************
// command register fields
// ****************************************
`define FSLC_CMD_CODE_LSB 0
`define FSLC_CMD_BLK_LSB 8

// ****************************************
// status bit positions
// ****************************************
`define FSLC_ST_READY 7
`define FSLC_ST_ERASE_ERR 5
`define FSLC_ST_PROG_ERR 4
`define FSLC_ST_SUPPLY_LOW 3
`define FSLC_ST_WRITE_SUSP 2
`define FSLC_ST_LOCK_VIOL 1

// ****************************************
// info bit positions
// ****************************************
`define FSLC_INFO_LOCK_UNKNOWN 0
`define FSLC_INFO_CHIP_SKIPPED 1
`define FSLC_INFO_PIN_MODE_LSB 2
`define FSLC_INFO_READ_ARRAY 4

// ****************************************
// status pin configuration codes
// ****************************************
`define FSLC_PIN_LEVEL 2'h0
`define FSLC_PIN_MAX_CODE 8'h03

// ****************************************
// timing
// ****************************************
`define FSLC_CLK_PERIOD_NS 10
`define FSLC_PULSE_NS 250
`define FSLC_PULSE_CYCLES ((`FSLC_PULSE_NS + `FSLC_CLK_PERIOD_NS - 1) / `FSLC_CLK_PERIOD_NS)
`define FSLC_OP_CYCLES 200
`define FSLC_SUSPEND_CYCLES 20

// ****************************************
// bus responses
// ****************************************
`define FSLC_RESP_OKAY 2'h0
`define FSLC_RESP_SLVERR 2'h2

`endif

// file: src/fslc_sync.v
`timescale 1ns/1ps

module fslc_sync #(
  parameter WIDTH = 3
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // pins
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  always @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // fslc_sync

// file: verification/fslc_pin_model.sv
`timescale 1ns/1ps

module fslc_pin_model (
  // clock and control
  input wire logic aclk,
  input wire logic clr,
  // open-drain status pin
  input wire logic oe,
  input wire logic dout,
  output logic pin,
  // low-episode observation
  output logic [7:0] episodes,
  output logic [15:0] low_len
);
  logic [15:0] run_len;

  // external pull-up: released pin reads high
  assign pin = oe ? dout : 1'b1;

  always @(posedge aclk) begin
    if (clr) begin
      episodes <= 8'h0;
      low_len <= 16'h0;
      run_len <= 16'h0;
    end else if (!pin) begin
      run_len <= run_len + 16'h1;
      if (run_len == 16'h0) begin
        episodes <= episodes + 8'h1;
      end
    end else if (run_len != 16'h0) begin
      low_len <= run_len;
      run_len <= 16'h0;
    end
  end
endmodule // fslc_pin_model

// file: verification/fslc_top_sva.sv
`timescale 1ns/1ps

module fslc_top_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // pins
  input wire logic reset_powerdown_n,
  input wire logic status_pin_out,
  input wire logic status_pin_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before taken");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_write_refused: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  a_read_refused: assert property (rvalid |-> !arready)
    else $error("read accepted while data pending");
  a_write_reopen: assert property (bvalid && bready |=> !bvalid ##1 (awready && wready))
    else $error("write channel not reopened on time");
  a_pin_drain: assert property (status_pin_oe |-> !status_pin_out)
    else $error("status pin driven high");
  a_pin_rp_float: assert property (!reset_powerdown_n [*8] |-> !status_pin_oe)
    else $error("status pin driven during power-down");
endmodule // fslc_top_sva

bind fslc_top fslc_top_sva sva_u (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .reset_powerdown_n, .status_pin_out, .status_pin_oe);

// file: verification/test_fslc_top.sv
`timescale 1ns/1ps
`include "fslc_defines.vh"

module test_fslc_top;
  localparam PLS = 3;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0;
  logic [7:0] araddr = 0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic bready = 0;
  logic arvalid = 0;
  logic rready = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 4'hf;
  logic wp_n = 1;
  logic rp_n = 1;
  logic vpp_low = 0;
  logic pm_clr = 1;
  logic awready, wready, bvalid, arready, rvalid, pin_oe, pin_out, pin;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [7:0] episodes;
  logic [15:0] low_len;
  int failures = 0;
  int checked = 0;

  always #5 aclk = ~aclk;

  fslc_top #(.OP_CYCLES(16'd40), .SUSPEND_CYCLES(16'd2), .PULSE_CYCLES(16'd3)) dut_u (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .write_protect_n(wp_n), .reset_powerdown_n(rp_n),
    .program_supply_lockout_level(vpp_low), .status_pin_out(pin_out), .status_pin_oe(pin_oe));

  fslc_pin_model pm_u (.aclk(aclk), .clr(pm_clr), .oe(pin_oe), .dout(pin_out), .pin(pin),
    .episodes(episodes), .low_len(low_len));

  // ****************************************
  // reporting and bus tasks
  // ****************************************
  task results;
    $display("counts checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task tmo;
    chk(32'h0, 32'h1);
    results;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) break;
    end
    if (n == 60) tmo;
    chk(32'(bresp), 32'(er));
    bready <= 0;
  endtask

  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) break;
    end
    if (n == 60) tmo;
    rd = rdata;
    rs = rresp;
    rready <= 0;
  endtask

  task cmd(input logic [7:0] code, input logic [5:0] blk);
    wr(`FSLC_REG_CMD, {18'h0, blk, code}, `FSLC_RESP_OKAY);
  endtask

  task stat(input logic [31:0] e);
    rdr(`FSLC_REG_STATUS);
    chk(rd, e);
  endtask

  task automatic wait_rdy;
    int n;
    for (n = 0; n < 300; n++) begin
      rdr(`FSLC_REG_STATUS);
      if (rd[`FSLC_ST_READY] === 1'b1) break;
    end
    if (n == 300) tmo;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task t_bus;
    wr(8'h14, 32'h1, `FSLC_RESP_SLVERR);
    rdr(8'h14);
    chk(32'(rs), 32'(`FSLC_RESP_SLVERR));
    wr(`FSLC_REG_STATUS, 32'hff, `FSLC_RESP_OKAY);
    // command byte lane off: setup must be ignored
    wstrb <= 4'he;
    cmd(8'h60, 6'd0);
    wstrb <= 4'hf;
    cmd(8'h01, 6'd9);
    wait_rdy;
    stat(32'h80);
    rdr(`FSLC_REG_LOCK_LO);
    chk(rd, 32'h0);
    $display("test bus done");
  endtask

  task t_lock;
    cmd(8'h60, 6'd0);
    cmd(8'h01, 6'd5);
    wait_rdy;
    stat(32'h80);
    cmd(8'h60, 6'd0);
    cmd(8'h01, 6'd40);
    wait_rdy;
    rdr(`FSLC_REG_LOCK_LO);
    chk(rd, 32'h20);
    rdr(`FSLC_REG_LOCK_HI);
    chk(rd, 32'h100);
    wp_n <= 0;
    cyc(4);
    cmd(8'h60, 6'd0);
    cmd(8'h01, 6'd7);
    wait_rdy;
    stat(32'h92);
    cmd(8'h50, 6'd0);
    cmd(8'h40, 6'd0);
    cmd(8'h00, 6'd5);
    wait_rdy;
    stat(32'h92);
    cmd(8'h50, 6'd0);
    cmd(8'h60, 6'd0);
    cmd(8'hd0, 6'd0);
    wait_rdy;
    stat(32'ha2);
    cmd(8'h50, 6'd0);
    cmd(8'h20, 6'd0);
    cmd(8'hd0, 6'd5);
    wait_rdy;
    stat(32'ha2);
    cmd(8'h50, 6'd0);
    cmd(8'h30, 6'd0);
    cmd(8'hd0, 6'd0);
    wait_rdy;
    rdr(`FSLC_REG_INFO);
    chk(rd & 32'h2, 32'h2);
    wp_n <= 1;
    cyc(4);
    cmd(8'h30, 6'd0);
    cmd(8'hd0, 6'd0);
    wait_rdy;
    rdr(`FSLC_REG_INFO);
    chk(rd & 32'h2, 32'h0);
    cmd(8'h10, 6'd0);
    cmd(8'h00, 6'd5);
    wait_rdy;
    stat(32'h80);
    vpp_low <= 1;
    cyc(4);
    cmd(8'h60, 6'd0);
    cmd(8'hd0, 6'd0);
    wait_rdy;
    stat(32'ha8);
    rdr(`FSLC_REG_LOCK_LO);
    chk(rd, 32'h20);
    cmd(8'h50, 6'd0);
    vpp_low <= 0;
    cyc(4);
    cmd(8'h60, 6'd0);
    cmd(8'hd0, 6'd0);
    wait_rdy;
    stat(32'h80);
    rdr(`FSLC_REG_LOCK_LO);
    chk(rd, 32'h0);
    rdr(`FSLC_REG_LOCK_HI);
    chk(rd, 32'h0);
    $display("test lock done");
  endtask

  task t_bad;
    cmd(8'h60, 6'd0);
    cmd(8'h77, 6'd2);
    wait_rdy;
    stat(32'hb0);
    rdr(`FSLC_REG_LOCK_LO);
    chk(rd, 32'h0);
    cmd(8'h50, 6'd0);
    cmd(8'hb8, 6'd0);
    cmd(8'h04, 6'd0);
    wait_rdy;
    stat(32'hb0);
    cmd(8'h50, 6'd0);
    $display("test bad sequence done");
  endtask

  // write protect held steady across the suspend
  task t_susp;
    cmd(8'h40, 6'd0);
    cmd(8'h00, 6'd1);
    cmd(8'hb0, 6'd0);
    wait_rdy;
    stat(32'h84);
    chk(32'(pin), 32'h1);
    cmd(8'h20, 6'd0);
    stat(32'h84);
    cmd(8'hd0, 6'd0);
    stat(32'h00);
    chk(32'(pin), 32'h0);
    wait_rdy;
    stat(32'h80);
    cyc(2);
    chk(32'(pin), 32'h1);
    $display("test suspend done");
  endtask

  task automatic t_pin;
    int m;
    int op;
    logic [1:0] mv;
    logic [7:0] e;
    for (m = 0; m < 4; m++) begin
      mv = 2'(m);
      cmd(8'hb8, 6'd0);
      cmd({6'h0, mv}, 6'd0);
      for (op = 0; op < 2; op++) begin
        pm_clr <= 1;
        @(posedge aclk);
        pm_clr <= 0;
        cmd(8'h60, 6'd0);
        cmd(op == 0 ? 8'h01 : 8'hd0, 6'd3);
        wait_rdy;
        cyc(PLS + 8);
        e = (mv == 2'h0) ? 8'h1 : 8'(mv[1 - op]);
        chk(32'(episodes), 32'(e));
        if (mv != 2'h0 && e == 8'h1) chk(32'(low_len), PLS);
      end
    end
    $display("test pin modes done");
  endtask

  task t_rp;
    cmd(8'hb8, 6'd0);
    cmd(8'h02, 6'd0);
    cmd(8'h60, 6'd0);
    cmd(8'hd0, 6'd0);
    rp_n <= 0;
    cyc(4);
    cmd(8'hb8, 6'd0);
    cmd(8'h01, 6'd0);
    rp_n <= 1;
    cyc(6);
    rdr(`FSLC_REG_INFO);
    chk(rd & 32'h1d, 32'h11);
    stat(32'h80);
    chk(32'(pin), 32'h1);
    $display("test power-down done");
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    pm_clr <= 0;
    cyc(3);
    t_bus;
    t_lock;
    t_bad;
    t_susp;
    t_pin;
    t_rp;
    results;
  end
endmodule // test_fslc_top
